// File: inc/ata_host_ctl_pkg.sv
// Constants for the host status, busy and timer control block
package ata_host_ctl_pkg;
    // Register offsets
    localparam logic [7:0] FIRST_DRIVE_STATUS_OFS = 8'hB4;
    localparam logic [7:0] SECOND_DRIVE_STATUS_OFS = 8'hB5;
    localparam logic [7:0] SECTORS_PER_BLOCK_OFS = 8'hB6;
    localparam logic [7:0] BLOCK_SECTOR_COUNTER_OFS = 8'hB7;
    localparam logic [7:0] HOST_DOWN_TIMER_OFS = 8'hB9;
    localparam logic [7:0] BUSY_DELAY_VALUE_OFS = 8'hBA;
    localparam logic [7:0] INTERRUPT_TIMEOUT_VALUE_OFS = 8'hBB;
    localparam logic [7:0] HOST_PIN_CONTROL_OFS = 8'hBF;
    localparam logic [7:0] HOST_CONTROL_ZERO_OFS = 8'hC0;
    localparam logic [7:0] HOST_CONTROL_ONE_OFS = 8'hC1;
    localparam logic [7:0] TIMER_STATUS_OFS = 8'hC8;
    // Field positions
    localparam int READY_BIT = 2;
    localparam int WRITE_FAULT_BIT = 1;
    localparam int SEEK_DONE_BIT = 0;
    localparam int DIAG_CTRL_BIT = 6;
    localparam int SLAVE_CTRL_BIT = 5;
    localparam int AUTO_CMD_EN_BIT = 7;
    localparam int TF_UPD_DIS_BIT = 6;
    localparam int VERIFY_UPD_EN_BIT = 5;
    localparam int START_UPD_DIS_BIT = 4;
    localparam int CS1_SEL_BIT = 3;
    localparam int SECONDARY_ROLE_BIT = 2;
    localparam int DUAL_DRIVE_EN_BIT = 1;
    localparam int SET_BUSY_BIT = 7;
    localparam int CLEAR_BUSY_BIT = 6;
    localparam int MISSED_IRQ_BIT = 7;
    // Reset values
    localparam logic [7:0] DRIVE_STATUS_RST = 8'h00;
    localparam logic [7:0] PIN_CONTROL_RST = 8'h60;
    localparam logic [7:0] CONTROL_ZERO_RST = 8'h00;
    localparam logic [7:0] VALUE_RST = 8'h00;
    // Timer prescale in buffer clock periods, minus one
    localparam logic [10:0] BUSY_PRESCALE_LAST = 11'h00F;
    localparam logic [10:0] IRQ_PRESCALE_LAST = 11'h7FF;
    // Execute drive diagnostics command code
    localparam logic [7:0] DIAG_CMD = 8'h90;
    // Host timer modes
    typedef enum logic [1:0] {TMR_IDLE, TMR_BUSY, TMR_IRQ} timer_mode_e;
endpackage : ata_host_ctl_pkg

// File: verilog/ata_host_ctl.sv
// Host status mirror, block counter, busy/IRQ timer and pin control
//
// Local design decision: the plain strobed port.
`timescale 1ns/10ps
`default_nettype none

//////////////////////////////////////////////////////////////////////////////
// Behaviour
// [R1] Drive 0 selected: its ready, fault, seek bits appear as status 6,5,4.
// [R2] Drive 1 selected: its ready, fault, seek bits appear as status 6,5,4.
// [R3] Drive 1 register unused for status with two physical drives.
// [R4] Hard reset pin and power-on reset clear per-drive status bits.
// [R5] Firmware loads a nonzero sectors-per-block before multiple commands.
// [R6] Block counter loads from block size per block, decrements per sector.
// [R7] Busy-delay value loads the timer when busy sets, except last sector.
// [R8] Busy held 16 times delay ticks, then busy clears, DRQ and IRQ rise.
// [R9] Multi-sector reads load timeout on IRQ, 2048 ticks per count.
// [R10] Missed-interrupt flag sets only if timer expires before data read.
// [R11] Diag line low when bit clear, released when set; read shows pin.
// [R12] Diag bit set by soft reset, hard reset or diagnostics command.
// [R13] Slave line bit: released set, low clear; card mode drives other pins.
// [R14] Local auto command starts only while local auto enable is set.
// [R15] Task-file update disable stops task file updates.
// [R16] Verify-update enable updates task file per good verify sector.
// [R17] Start-update disable stops start register updates on read commands.
// [R18] Shared pin is chip select 1 when bit set, address 9 when clear.
// [R19] Dual-drive enable picks role by secondary bit, else answers both.
// [R20] Writing one to set-busy sets the busy latch; zero does nothing.
// [R21] Hard reset pin or host soft reset sets the busy latch.
// [R22] Host command write sets busy per role match, disabled or diag cmd.
// [R23] Two physical drives: drive-0 register serves both drive statuses.
// [R24] Clear-busy alone clears the latch; both bits together is illegal.
module ata_host_ctl (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWrEn,
    input wire logic regRdEn,
    output logic [7:0] regRdData,
    input wire logic hostHardResetPin,
    input wire logic hostSoftReset,
    input wire logic hostCmdWrite,
    input wire logic [7:0] hostCmdCode,
    input wire logic driveSelect,
    input wire logic hostDataRead,
    input wire logic bufferClockTick,
    input wire logic autoXferActive,
    input wire logic readXfer,
    input wire logic sectorDone,
    input wire logic lastSector,
    input wire logic blockStart,
    input wire logic localCmdWrite,
    input wire logic localCmdAutoOk,
    input wire logic verifyGoodSector,
    input wire logic readCmdLoad,
    input wire logic cardMode,
    input wire logic configIndexNonzero,
    input wire logic sharedPinIn,
    input wire logic diagPassedIn,
    input wire logic slavePresentIn,
    output logic [2:0] hostStatusBits,
    output logic busyFlag,
    output logic drqSet,
    output logic irqSet,
    output logic missedIrq,
    output logic respondDrive0,
    output logic respondDrive1,
    output logic chipSelectOne_n,
    output logic hostAddr9,
    output logic autoStart,
    output logic taskFileUpdate,
    output logic startRegUpdate,
    output logic diagPassedOut,
    output logic diagPassedOe,
    output logic slavePresentOut,
    output logic slavePresentOe,
    output logic speakerLine,
    output logic batteryStatusLine
);

    //////////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    logic [3:0] pinMeta_q;
    logic [3:0] pinSync_q;

    always_ff @(posedge core_clk) begin
        pinMeta_q <= {hostHardResetPin, sharedPinIn, diagPassedIn,
                      slavePresentIn};
        pinSync_q <= pinMeta_q;
    end

    logic hardReset;
    assign hardReset = pinSync_q[3];

    //////////////////////////////////////////////////////////////////////////
    // Register decode
    logic [7:0] first_drive_status_q, second_drive_status_q, blkSize_q, blkCtr_q, timer_q;
    logic [7:0] busyVal_q, irqVal_q, pinCtl_q, ctl0_q;
    logic busy_q, missed_q;

    logic wrDrv0, wrDrv1, wrBlkSize, wrBusyVal, wrIrqVal, wrPinCtl;
    logic wrCtl0, wrCtl1;
    assign wrDrv0 = regWrEn && regAddr == ata_host_ctl_pkg::FIRST_DRIVE_STATUS_OFS;
    assign wrDrv1 = regWrEn && regAddr == ata_host_ctl_pkg::SECOND_DRIVE_STATUS_OFS;
    assign wrBlkSize = regWrEn && regAddr == ata_host_ctl_pkg::SECTORS_PER_BLOCK_OFS;
    assign wrBusyVal = regWrEn && regAddr == ata_host_ctl_pkg::BUSY_DELAY_VALUE_OFS;
    assign wrIrqVal = regWrEn
        && regAddr == ata_host_ctl_pkg::INTERRUPT_TIMEOUT_VALUE_OFS;
    assign wrPinCtl = regWrEn && regAddr == ata_host_ctl_pkg::HOST_PIN_CONTROL_OFS;
    assign wrCtl0 = regWrEn && regAddr == ata_host_ctl_pkg::HOST_CONTROL_ZERO_OFS;
    assign wrCtl1 = regWrEn && regAddr == ata_host_ctl_pkg::HOST_CONTROL_ONE_OFS;

    // Control fields
    logic autoCmdEn, tfUpdDis, verifyUpdEn, startUpdDis, cs1Sel;
    logic secondaryRole, dualDriveEn;
    assign autoCmdEn = ctl0_q[ata_host_ctl_pkg::AUTO_CMD_EN_BIT];
    assign tfUpdDis = ctl0_q[ata_host_ctl_pkg::TF_UPD_DIS_BIT];
    assign verifyUpdEn = ctl0_q[ata_host_ctl_pkg::VERIFY_UPD_EN_BIT];
    assign startUpdDis = ctl0_q[ata_host_ctl_pkg::START_UPD_DIS_BIT];
    assign cs1Sel = ctl0_q[ata_host_ctl_pkg::CS1_SEL_BIT];
    assign secondaryRole = ctl0_q[ata_host_ctl_pkg::SECONDARY_ROLE_BIT];
    assign dualDriveEn = ctl0_q[ata_host_ctl_pkg::DUAL_DRIVE_EN_BIT];

    // Read mux; write-only and unmapped offsets read zero
    logic [7:0] rdMux;
    assign rdMux =
        (regAddr == ata_host_ctl_pkg::FIRST_DRIVE_STATUS_OFS) ? first_drive_status_q :
        (regAddr == ata_host_ctl_pkg::SECOND_DRIVE_STATUS_OFS) ? second_drive_status_q :
        (regAddr == ata_host_ctl_pkg::SECTORS_PER_BLOCK_OFS) ? blkSize_q :
        (regAddr == ata_host_ctl_pkg::BLOCK_SECTOR_COUNTER_OFS) ? blkCtr_q :
        (regAddr == ata_host_ctl_pkg::HOST_DOWN_TIMER_OFS) ? timer_q :
        (regAddr == ata_host_ctl_pkg::HOST_PIN_CONTROL_OFS) ?
            {1'b0, pinSync_q[1], pinSync_q[0], 5'h00} :    // R11
        (regAddr == ata_host_ctl_pkg::HOST_CONTROL_ZERO_OFS) ? ctl0_q :
        (regAddr == ata_host_ctl_pkg::HOST_CONTROL_ONE_OFS) ?
            {busy_q, 7'h00} :
        (regAddr == ata_host_ctl_pkg::TIMER_STATUS_OFS) ?
            {missed_q, 7'h00} : 8'h00;

    always_ff @(posedge core_clk) begin
        if (sys_rst) regRdData <= 8'h00;
        else regRdData <= regRdEn ? rdMux : 8'h00;
    end

    //////////////////////////////////////////////////////////////////////////
    // Plain registers
    always_ff @(posedge core_clk) begin
        if (sys_rst || hardReset) begin                          // R4
            first_drive_status_q <= ata_host_ctl_pkg::DRIVE_STATUS_RST;
            second_drive_status_q <= ata_host_ctl_pkg::DRIVE_STATUS_RST;
        end else begin
            if (wrDrv0) first_drive_status_q <= {5'h00, regWrData[2:0]};
            if (wrDrv1) second_drive_status_q <= {5'h00, regWrData[2:0]};
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            blkSize_q <= ata_host_ctl_pkg::VALUE_RST;
            busyVal_q <= ata_host_ctl_pkg::VALUE_RST;
            irqVal_q <= ata_host_ctl_pkg::VALUE_RST;
            ctl0_q <= ata_host_ctl_pkg::CONTROL_ZERO_RST;
        end else begin
            if (wrBlkSize) blkSize_q <= regWrData;               // R5
            if (wrBusyVal) busyVal_q <= regWrData;
            if (wrIrqVal) irqVal_q <= regWrData;
            if (wrCtl0) ctl0_q <= {regWrData[7:1], 1'b0};
        end
    end

    // Pin control bits: resets force both set; the diagnostics command sets only the diag bit
    logic diagCmd, pinForce, diagSet;
    assign diagCmd = hostCmdWrite && hostCmdCode == ata_host_ctl_pkg::DIAG_CMD;
    assign pinForce = hardReset || hostSoftReset;
    assign diagSet = pinForce || diagCmd;                        // R12

    always_ff @(posedge core_clk) begin
        if (sys_rst) pinCtl_q <= ata_host_ctl_pkg::PIN_CONTROL_RST;
        else begin
            if (wrPinCtl) pinCtl_q <= {1'b0, regWrData[6:5], 5'h00};
            if (diagSet) pinCtl_q[ata_host_ctl_pkg::DIAG_CTRL_BIT] <= 1'b1;
            if (pinForce) pinCtl_q[ata_host_ctl_pkg::SLAVE_CTRL_BIT] <= 1'b1;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Block sector counter
    always_ff @(posedge core_clk) begin
        if (sys_rst) blkCtr_q <= ata_host_ctl_pkg::VALUE_RST;
        else if (blockStart) blkCtr_q <= blkSize_q;              // R6
        else if (sectorDone && blkCtr_q != 8'h00)
            blkCtr_q <= blkCtr_q - 8'h01;                        // R6
    end

    //////////////////////////////////////////////////////////////////////////
    // Busy latch
    logic roleMatch, hostBusySet, busySetEvt, cpuSet, cpuClear;
    logic busyRelease;
    assign roleMatch = driveSelect == secondaryRole;
    assign hostBusySet = hostCmdWrite
        && (!dualDriveEn || roleMatch || diagCmd);               // R22
    assign cpuSet = wrCtl1 && regWrData[ata_host_ctl_pkg::SET_BUSY_BIT];
    assign cpuClear = wrCtl1 && regWrData[ata_host_ctl_pkg::CLEAR_BUSY_BIT]
        && !regWrData[ata_host_ctl_pkg::SET_BUSY_BIT];           // R24
    assign busySetEvt = cpuSet || pinForce || hostBusySet;       // R20 R21

    always_ff @(posedge core_clk) begin
        if (sys_rst) busy_q <= 1'b0;
        else if (busySetEvt) busy_q <= 1'b1;
        else if (cpuClear || busyRelease) busy_q <= 1'b0;
    end

    //////////////////////////////////////////////////////////////////////////
    // Host down-timer
    ata_host_ctl_pkg::timer_mode_e mode_q;
    logic [10:0] pre_q;
    logic busyLoad, expired, tickLast;
    assign busyLoad = autoXferActive
        && (hostBusySet || (sectorDone && !lastSector));         // R7
    assign expired = timer_q == 8'h00;
    assign tickLast = pre_q == ((mode_q == ata_host_ctl_pkg::TMR_IRQ)
        ? ata_host_ctl_pkg::IRQ_PRESCALE_LAST
        : ata_host_ctl_pkg::BUSY_PRESCALE_LAST);
    assign busyRelease = mode_q == ata_host_ctl_pkg::TMR_BUSY && expired;

    logic irqLoad, timeout;
    assign irqLoad = busyRelease && readXfer;                    // R9
    assign timeout = mode_q == ata_host_ctl_pkg::TMR_IRQ && expired
        && !hostDataRead;                                        // R10

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            mode_q <= ata_host_ctl_pkg::TMR_IDLE;
            timer_q <= ata_host_ctl_pkg::VALUE_RST;
            pre_q <= 11'h000;
        end else if (busyLoad) begin
            mode_q <= ata_host_ctl_pkg::TMR_BUSY;
            timer_q <= busyVal_q;                                // R7
            pre_q <= 11'h000;
        end else if (irqLoad) begin
            mode_q <= ata_host_ctl_pkg::TMR_IRQ;
            timer_q <= irqVal_q;                                 // R9
            pre_q <= 11'h000;
        end else begin
            unique case (mode_q)
                ata_host_ctl_pkg::TMR_IDLE: begin
                    pre_q <= 11'h000;
                end
                ata_host_ctl_pkg::TMR_BUSY,
                ata_host_ctl_pkg::TMR_IRQ: begin
                    if (expired || (mode_q == ata_host_ctl_pkg::TMR_IRQ
                            && hostDataRead)) begin
                        mode_q <= ata_host_ctl_pkg::TMR_IDLE;
                    end else if (bufferClockTick) begin
                        pre_q <= tickLast ? 11'h000 : pre_q + 11'h001;
                        if (tickLast) timer_q <= timer_q - 8'h01; // R8
                    end
                end
                default: mode_q <= ata_host_ctl_pkg::TMR_IDLE;
            endcase
        end
    end

    // Missed interrupt flag; a new timeout wins over the clear
    always_ff @(posedge core_clk) begin
        if (sys_rst) missed_q <= 1'b0;
        else if (timeout) missed_q <= 1'b1;                      // R10
        else if (hostCmdWrite) missed_q <= 1'b0;
    end

    //////////////////////////////////////////////////////////////////////////
    // Status mirror and drive selection
    logic useDrv1;
    logic [7:0] selStat;
    assign useDrv1 = driveSelect && !dualDriveEn;                // R3 R23
    assign selStat = useDrv1 ? second_drive_status_q : first_drive_status_q;          // R1 R2

    //////////////////////////////////////////////////////////////////////////
    // Output flops
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            hostStatusBits <= 3'h0;
            busyFlag <= 1'b0;
            drqSet <= 1'b0;
            irqSet <= 1'b0;
            missedIrq <= 1'b0;
            respondDrive0 <= 1'b1;
            respondDrive1 <= 1'b1;
            chipSelectOne_n <= 1'b1;
            hostAddr9 <= 1'b0;
            autoStart <= 1'b0;
            taskFileUpdate <= 1'b0;
            startRegUpdate <= 1'b0;
            diagPassedOe <= 1'b0;
            slavePresentOe <= 1'b0;
            speakerLine <= 1'b1;
            batteryStatusLine <= 1'b1;
        end else begin
            hostStatusBits <= {selStat[ata_host_ctl_pkg::READY_BIT],
                               selStat[ata_host_ctl_pkg::WRITE_FAULT_BIT],
                               selStat[ata_host_ctl_pkg::SEEK_DONE_BIT]};
            busyFlag <= busy_q;
            drqSet <= busyRelease;                               // R8
            irqSet <= busyRelease;                               // R8
            missedIrq <= missed_q;
            respondDrive0 <= !dualDriveEn || !secondaryRole;     // R19
            respondDrive1 <= !dualDriveEn || secondaryRole;      // R19
            chipSelectOne_n <= cs1Sel ? pinSync_q[2] : 1'b1;     // R18
            hostAddr9 <= cs1Sel ? 1'b0 : pinSync_q[2];           // R18
            autoStart <= localCmdWrite && localCmdAutoOk && autoCmdEn; // R14
            taskFileUpdate <= !tfUpdDis                          // R15
                && (sectorDone || (verifyGoodSector && verifyUpdEn)); // R16
            startRegUpdate <= readCmdLoad && !startUpdDis;       // R17
            diagPassedOe <= !pinCtl_q[ata_host_ctl_pkg::DIAG_CTRL_BIT]; // R11
            slavePresentOe <= !cardMode
                && !pinCtl_q[ata_host_ctl_pkg::SLAVE_CTRL_BIT];  // R13
            speakerLine <= (cardMode && configIndexNonzero)
                ? pinCtl_q[ata_host_ctl_pkg::SLAVE_CTRL_BIT] : 1'b1; // R13
            batteryStatusLine <= (cardMode && !configIndexNonzero)
                ? pinCtl_q[ata_host_ctl_pkg::SLAVE_CTRL_BIT] : 1'b1; // R13
        end
    end

    // Both open-drain lines only ever pull low
    assign diagPassedOut = 1'b0;
    assign slavePresentOut = 1'b0;

    //////////////////////////////////////////////////////////////////////////
    // Checks
    a_drive_zero_mirror: assert property (@(posedge core_clk) // R1
        disable iff (sys_rst) !driveSelect |=> hostStatusBits ==
        $past(first_drive_status_q[2:0])) else $error("drive 0 status not mirrored");

    a_dual_uses_first: assert property (@(posedge core_clk) // R23
        disable iff (sys_rst) dualDriveEn |=> hostStatusBits ==
        $past(first_drive_status_q[2:0])) else $error("two drives use drive 0 status");

    a_status_hard_clear: assert property (@(posedge core_clk) // R4
        disable iff (sys_rst) hardReset |=> first_drive_status_q == 8'h00
        && second_drive_status_q == 8'h00) else $error("status not cleared");

    a_block_load: assert property (@(posedge core_clk) // R6
        disable iff (sys_rst) blockStart |=> blkCtr_q == $past(blkSize_q))
        else $error("block counter not loaded");

    a_busy_release: assert property (@(posedge core_clk) // R8
        disable iff (sys_rst) busyLoad && busyVal_q == 8'h00 && !busySetEvt
        ##1 !busyLoad && !busySetEvt |=> !busy_q && drqSet && irqSet)
        else $error("zero delay did not release busy");

    a_missed_flag: assert property (@(posedge core_clk) // R10
        disable iff (sys_rst) $rose(missed_q) |->
        $past(mode_q == ata_host_ctl_pkg::TMR_IRQ && !hostDataRead))
        else $error("missed flag without timeout");

    a_diag_set: assert property (@(posedge core_clk) // R12
        disable iff (sys_rst) diagCmd |=> ##1 !diagPassedOe)
        else $error("diagnostics command did not release line");

    a_cpu_set_busy: assert property (@(posedge core_clk) // R20
        disable iff (sys_rst) cpuSet |=> busy_q ##1 busyFlag)
        else $error("set busy write ignored");

    a_cpu_clear_busy: assert property (@(posedge core_clk) // R24
        disable iff (sys_rst) cpuClear && !busySetEvt |=> !busy_q)
        else $error("clear busy write ignored");

    a_auto_gate: assert property (@(posedge core_clk) // R14
        disable iff (sys_rst) autoStart |-> $past(autoCmdEn))
        else $error("auto start while disabled");

endmodule : ata_host_ctl
`default_nettype wire

// File: verif/ata_host_model.sv
// Host adapter model: command strobes, buffer clock ticks, pulled-up pins
`timescale 1ns/10ps
`default_nettype none
module ata_host_model (
    input wire logic core_clk,
    input wire logic diagPassedOe,
    input wire logic slavePresentOe,
    output logic hostCmdWrite,
    output logic [7:0] hostCmdCode,
    output logic hostDataRead,
    output logic bufferClockTick,
    output logic diagPassedIn,
    output logic slavePresentIn
);
    // Both lines carry pull-ups, so a released line reads high
    assign diagPassedIn = !diagPassedOe;
    assign slavePresentIn = !slavePresentOe;

    // Buffer clock runs with the core clock to keep timer runs short
    initial begin
        hostCmdWrite = 1'b0;
        hostCmdCode = 8'h00;
        hostDataRead = 1'b0;
        bufferClockTick = 1'b1;
    end

    // One-cycle command register write from the host
    task automatic cmd(input logic [7:0] code);
        @(posedge core_clk);
        hostCmdWrite <= 1'b1;
        hostCmdCode <= code;
        @(posedge core_clk);
        hostCmdWrite <= 1'b0;
    endtask : cmd

    // One-cycle data read cycle from the host
    task automatic data_read();
        @(posedge core_clk);
        hostDataRead <= 1'b1;
        @(posedge core_clk);
        hostDataRead <= 1'b0;
    endtask : data_read
endmodule : ata_host_model
`default_nettype wire

// File: verif/ata_host_ctl_tb.sv
// Bench for the host status, busy and timer control block
`timescale 1ns/10ps
`default_nettype none
module ata_host_ctl_tb;
    logic core_clk;
    logic sys_rst = 1'b1;
    logic [7:0] regAddr = 8'h00, regWrData = 8'h00, regRdData, hostCmdCode;
    logic regWrEn = 1'b0, regRdEn = 1'b0, hostHardResetPin = 1'b0;
    logic hostSoftReset = 1'b0, driveSelect = 1'b0, autoXferActive = 1'b0;
    logic readXfer = 1'b0, sectorDone = 1'b0, lastSector = 1'b0;
    logic blockStart = 1'b0, localCmdWrite = 1'b0, localCmdAutoOk = 1'b0;
    logic verifyGoodSector = 1'b0, readCmdLoad = 1'b0, cardMode = 1'b0;
    logic configIndexNonzero = 1'b0, sharedPinIn = 1'b0;
    logic hostCmdWrite, hostDataRead, bufferClockTick, diagPassedIn;
    logic slavePresentIn, busyFlag, drqSet, irqSet, missedIrq;
    logic respondDrive0, respondDrive1, chipSelectOne_n, hostAddr9;
    logic autoStart, taskFileUpdate, startRegUpdate, diagPassedOut;
    logic diagPassedOe, slavePresentOut, slavePresentOe, speakerLine;
    logic batteryStatusLine;
    logic [2:0] hostStatusBits;
    int miscompares = 0, num_checks = 0;

    ata_host_ctl i_dut (.core_clk, .sys_rst, .regAddr, .regWrData, .regWrEn,
        .regRdEn, .regRdData, .hostHardResetPin, .hostSoftReset,
        .hostCmdWrite, .hostCmdCode, .driveSelect, .hostDataRead,
        .bufferClockTick, .autoXferActive, .readXfer, .sectorDone,
        .lastSector, .blockStart, .localCmdWrite, .localCmdAutoOk,
        .verifyGoodSector, .readCmdLoad, .cardMode, .configIndexNonzero,
        .sharedPinIn, .diagPassedIn, .slavePresentIn, .hostStatusBits,
        .busyFlag, .drqSet, .irqSet, .missedIrq, .respondDrive0,
        .respondDrive1, .chipSelectOne_n, .hostAddr9, .autoStart,
        .taskFileUpdate, .startRegUpdate, .diagPassedOut, .diagPassedOe,
        .slavePresentOut, .slavePresentOe, .speakerLine, .batteryStatusLine);
    ata_host_model i_host (.core_clk, .diagPassedOe, .slavePresentOe,
        .hostCmdWrite, .hostCmdCode, .hostDataRead, .bufferClockTick,
        .diagPassedIn, .slavePresentIn);

    //////////////////////////////////////////////////////////////////////////
    // Clock and shared helpers
    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end

    task automatic chk(input string nm, input logic [7:0] seen, exp);
        num_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic step(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask : step

    task automatic wr(input logic [7:0] a, d);
        @(posedge core_clk);
        regAddr <= a;
        regWrData <= d;
        regWrEn <= 1'b1;
        @(posedge core_clk);
        regWrEn <= 1'b0;
    endtask : wr

    task automatic rdchk(input string nm, input logic [7:0] a, exp);
        @(posedge core_clk);
        regAddr <= a;
        regRdEn <= 1'b1;
        @(posedge core_clk);
        regRdEn <= 1'b0;
        #1;
        chk(nm, regRdData, exp);
    endtask : rdchk

    //////////////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic t_status();
        wr(ata_host_ctl_pkg::FIRST_DRIVE_STATUS_OFS, 8'h05);
        wr(ata_host_ctl_pkg::SECOND_DRIVE_STATUS_OFS, 8'h02);
        step(3);
        chk("status drive0", hostStatusBits, 8'h05);
        driveSelect <= 1'b1;
        step(3);
        chk("status drive1", hostStatusBits, 8'h02);
        wr(ata_host_ctl_pkg::HOST_CONTROL_ZERO_OFS, 8'h02);
        step(3);
        chk("status dual", hostStatusBits, 8'h05);
        hostHardResetPin <= 1'b1;
        step(4);
        hostHardResetPin <= 1'b0;
        step(4);
        chk("status hard reset", hostStatusBits, 8'h00);
        rdchk("drive0 reg", 8'hB4, 8'h00);
        chk("busy hard reset", busyFlag, 8'h01);
        rdchk("pin ctl", 8'hBF, 8'h60);
        $display("status test done");
    endtask : t_status

    task automatic t_busy();
        wr(ata_host_ctl_pkg::HOST_CONTROL_ONE_OFS, 8'h40);
        step(2);
        chk("busy clear", busyFlag, 8'h00);
        wr(ata_host_ctl_pkg::HOST_CONTROL_ONE_OFS, 8'h80);
        wr(ata_host_ctl_pkg::HOST_CONTROL_ONE_OFS, 8'h00);
        step(2);
        chk("busy set", busyFlag, 8'h01);
        wr(ata_host_ctl_pkg::HOST_CONTROL_ONE_OFS, 8'h40);
        wr(ata_host_ctl_pkg::HOST_CONTROL_ZERO_OFS, 8'h06);
        wr(ata_host_ctl_pkg::HOST_PIN_CONTROL_OFS, 8'h00);
        driveSelect <= 1'b0;
        step(3);
        chk("pin drive", {diagPassedOe, slavePresentOe}, 8'h03);
        chk("role", {respondDrive0, respondDrive1}, 8'h01);
        i_host.cmd(8'h20);
        step(2);
        chk("busy mismatch", busyFlag, 8'h00);
        i_host.cmd(ata_host_ctl_pkg::DIAG_CMD);
        step(4);
        chk("busy diag", busyFlag, 8'h01);
        rdchk("diag pin", 8'hBF, 8'h40);
        wr(ata_host_ctl_pkg::HOST_CONTROL_ONE_OFS, 8'h40);
        hostSoftReset <= 1'b1;
        step(2);
        hostSoftReset <= 1'b0;
        step(2);
        chk("busy soft reset", busyFlag, 8'h01);
        $display("busy test done");
    endtask : t_busy

    task automatic t_block();
        wr(ata_host_ctl_pkg::SECTORS_PER_BLOCK_OFS, 8'h03);
        blockStart <= 1'b1;
        step(1);
        blockStart <= 1'b0;
        rdchk("counter load", 8'hB7, 8'h03);
        sectorDone <= 1'b1;
        step(2);
        sectorDone <= 1'b0;
        wr(ata_host_ctl_pkg::BLOCK_SECTOR_COUNTER_OFS, 8'hFF);
        rdchk("counter count", 8'hB7, 8'h01);
        rdchk("write only", 8'hBA, 8'h00);
        rdchk("unmapped", 8'hB8, 8'h00);
        $display("block test done");
    endtask : t_block

    task automatic t_ctl();
        logic s;
        wr(ata_host_ctl_pkg::HOST_CONTROL_ZERO_OFS, 8'h08);
        step(4);
        chk("chip select", chipSelectOne_n, 8'h00);
        wr(ata_host_ctl_pkg::HOST_CONTROL_ZERO_OFS, 8'h00);
        sharedPinIn <= 1'b1;
        step(4);
        chk("address 9", hostAddr9, 8'h01);
        localCmdAutoOk <= 1'b1;
        for (int j = 0; j < 2; j++) begin
            wr(ata_host_ctl_pkg::HOST_CONTROL_ZERO_OFS, j ? 8'h80 : 8'h00);
            localCmdWrite <= 1'b1;
            step(1);
            localCmdWrite <= 1'b0;
            s = 1'b0;
            repeat (3) begin
                s = s | (autoStart === 1'b1);
                step(1);
            end
            chk("auto start", s, j[7:0]);
        end
        $display("control test done");
    endtask : t_ctl

    task automatic t_timer();
        int n;
        wr(ata_host_ctl_pkg::HOST_CONTROL_ZERO_OFS, 8'h00);
        wr(ata_host_ctl_pkg::HOST_CONTROL_ONE_OFS, 8'h40);
        wr(8'hBA, 8'h01);
        wr(8'hBB, 8'h01);
        autoXferActive <= 1'b1;
        readXfer <= 1'b1;
        for (int k = 0; k < 2; k++) begin
            i_host.cmd(8'h20);
            n = 0;
            while (irqSet !== 1'b1 && n < 100) begin
                step(1);
                n++;
            end
            chk("busy hold", n >= 16 && n < 100, 8'h01);
            chk("drq", drqSet, 8'h01);
            if (k == 0) i_host.data_read();
            step(2100);
            rdchk("missed", 8'hC8, k ? 8'h80 : 8'h00);
        end
        wr(8'hBA, 8'h00);
        sectorDone <= 1'b1;
        step(1);
        sectorDone <= 1'b0;
        autoXferActive <= 1'b0;
        $display("timer test done");
    endtask : t_timer

    //////////////////////////////////////////////////////////////////////////
    // Sequence, watchdog and verdict
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : print_verdict

    initial begin
        repeat (2) @(posedge core_clk);
        sys_rst <= 1'b0;
        t_status();
        t_busy();
        t_block();
        t_ctl();
        t_timer();
        print_verdict();
    end

    initial begin
        repeat (20000) @(posedge core_clk);
        miscompares++;
        print_verdict();
    end
endmodule : ata_host_ctl_tb
`default_nettype wire
